// file: include/pwm_pkg.sv
package pwm_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CTL = 8'hAE;
  localparam logic [7:0] IDX_A_LO = 8'hAF;
  localparam logic [7:0] IDX_A_HI = 8'hB0;
  localparam logic [7:0] IDX_B_LO = 8'hB1;
  localparam logic [7:0] IDX_B_HI = 8'hB2;
  localparam logic [7:0] IDX_ROUTE = 8'hB3;
  localparam logic [7:0] IDX_COUNT = 8'hB4;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam int ADR_W = 10;

  // ---------------------------------------------------------------
  // Counter and prescaler constants
  // ---------------------------------------------------------------
  localparam logic [15:0] CNT_TOP = 16'hFFFF;
  localparam logic [3:0] DIV15_LAST = 4'hE;
  localparam logic [5:0] PRE_LAST_1 = 6'h00;
  localparam logic [5:0] PRE_LAST_4 = 6'h03;
  localparam logic [5:0] PRE_LAST_16 = 6'h0F;
  localparam logic [5:0] PRE_LAST_64 = 6'h3F;
  localparam logic [5:0] PRE_HALF_4 = 6'h01;
  localparam logic [5:0] PRE_HALF_16 = 6'h07;
  localparam logic [5:0] PRE_HALF_64 = 6'h1F;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_SINGLE = 3'b001,
    MODE_TWIN8 = 3'b010,
    MODE_TWIN16 = 3'b011,
    MODE_NRZ = 3'b100,
    MODE_DUAL8 = 3'b101,
    MODE_RZ = 3'b110,
    MODE_RSVD = 3'b111
  } mode_t;

  typedef enum logic [1:0] {
    SRC_OSC_DIV15 = 2'b00,
    SRC_OSC_DIV = 2'b01,
    SRC_EXT = 2'b10,
    SRC_OSC = 2'b11
  } src_t;

  typedef enum logic [1:0] {
    PRE_1 = 2'b00,
    PRE_4 = 2'b01,
    PRE_16 = 2'b10,
    PRE_64 = 2'b11
  } pre_t;

  typedef struct packed {
    logic first_output_off;
    mode_t mode;
    pre_t prescale;
    src_t clock_source;
  } ctl_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// file: verilog/pwm_clock_gen.sv
`timescale 1ns/10ps
module pwm_clock_gen #(
  parameter logic [7:0] OSC_DIV_LAST = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input pwm_pkg::src_t src_i,
  input pwm_pkg::pre_t pre_i,
  input wire logic ext_i,
  // Modulator clock strobes
  output logic tick_o,
  output logic half_o
);
  import pwm_pkg::*;

  typedef struct packed {
    logic [7:0] osc;
    logic [3:0] c15;
    logic ext_prev;
    logic [5:0] pre;
    logic tick;
    logic half;
  } gen_t;

  gen_t st;
  gen_t next_st;
  logic osc_en;
  logic src_en;
  logic [5:0] last;
  logic [5:0] mid;

  function automatic logic [5:0] pre_last(input pre_t p);
    case (p)
      PRE_4: return PRE_LAST_4;
      PRE_16: return PRE_LAST_16;
      PRE_64: return PRE_LAST_64;
      default: return PRE_LAST_1;
    endcase
  endfunction

  function automatic logic [5:0] pre_half(input pre_t p);
    case (p)
      PRE_4: return PRE_HALF_4;
      PRE_16: return PRE_HALF_16;
      PRE_64: return PRE_HALF_64;
      default: return PRE_LAST_1;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    osc_en = (st.osc == OSC_DIV_LAST);
    next_st.osc = osc_en ? '0 : st.osc + 8'h01;
    next_st.ext_prev = ext_i;
    if (osc_en)
    begin
      next_st.c15 = (st.c15 == DIV15_LAST) ? '0 : st.c15 + 4'h1;
    end
    // Clock source select [RL3]
    case (src_i)
      SRC_OSC_DIV15: src_en = osc_en && (st.c15 == DIV15_LAST);
      SRC_OSC_DIV: src_en = osc_en;
      SRC_EXT: src_en = ext_i && !st.ext_prev;
      default: src_en = 1'b1;
    endcase
    // Prescaler /1 /4 /16 /64 [RL2]
    last = pre_last(pre_i);
    mid = pre_half(pre_i);
    next_st.tick = src_en && (st.pre == last);
    next_st.half = src_en && (st.pre == mid) && (last != PRE_LAST_1);
    if (src_en)
    begin
      next_st.pre = (st.pre == last) ? '0 : st.pre + 6'h01;
    end
    if (clear_i)
    begin
      next_st.pre = '0;
      next_st.tick = 1'b0;
      next_st.half = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;
  assign half_o = st.half;

endmodule

// file: verilog/dual_pwm_sigma_delta_unit.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/10ps
// Function
// [RL1] Mode field bits 6..4 selects seven modes
// [RL2] Prescaler divides selected clock by 1/4/16/64
// [RL3] Bits 1..0 choose modulator clock source
// [RL4] Bit 7 releases the first output pin
// [RL5] Control write clears the modulator counter
// [RL6] Wide modes: low byte goes to holding
// [RL7] High write transfers pair; applies next cycle
// [RL8] Routing register picks one of two pairs
// [RL9] Disabled mode releases both output pins
// [RL10] Single: B sets period, A duty
// [RL11] Twin 8-bit: B low byte sets period
// [RL12] Twin 8-bit: A low at A-low match
// [RL13] Twin 8-bit: B high/low on byte matches
// [RL14] Twin 16-bit: counter runs full 65536
// [RL15] Twin 16-bit: first high below value A
// [RL16] Twin 16-bit: second high below value B
// [RL17] Twin 16-bit: both rise at wrap
// [RL18] Sigma-delta: outputs update every modulator clock
// [RL19] Sigma-delta: exact high count per 65536
// [RL20] Sigma-delta: high clocks spread evenly
// [RL21] Dual 8-bit: own period and duty each
// [RL22] Return-to-zero: high half, then low half; with prescaler /1 the code never returns low
// [RL23] 8-bit/single: wrap after period, A high
// [RL24] Reserved mode acts as disabled
module dual_pwm_sigma_delta_unit #(
  parameter logic [7:0] OSC_DIV_LAST = 8'h00
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input pwm_pkg::wb_req_t wb_i,
  output logic ack_o,
  output logic [31:0] dat_o,
  // External clock input
  input wire logic external_count_input_i,
  // Output pins
  output logic first_output_pin_o,
  output logic first_output_pin_oe_o,
  output logic second_output_pin_o,
  output logic second_output_pin_oe_o,
  output logic alternate_first_pin_o,
  output logic alternate_first_pin_oe_o,
  output logic alternate_second_pin_o,
  output logic alternate_second_pin_oe_o
);
  import pwm_pkg::*;

  typedef struct packed {
    ctl_t ctl;
    logic route;
    logic [7:0] hold_a;
    logic [7:0] hold_b;
    logic [15:0] stg_a;
    logic [15:0] stg_b;
    logic [15:0] act_a;
    logic [15:0] act_b;
    logic [15:0] cnt;
    logic [7:0] cnt2;
    logic [15:0] acc_a;
    logic [15:0] acc_b;
    logic lvl_a;
    logic lvl_b;
    logic [3:0] pin;
    logic [3:0] oe;
    logic ack;
    logic [31:0] dat;
  } state_t;

  state_t st;
  state_t next_st;
  logic tick;
  logic half;
  logic wr;
  logic ctl_wr;
  logic [7:0] idx;
  logic [7:0] d;
  logic wide;
  logic wrap;
  logic wrap2;
  logic [15:0] la;
  logic [15:0] lb;
  logic [15:0] nc;
  logic [7:0] nc2;
  logic [16:0] sa;
  logic [16:0] sb;
  logic en_a;
  logic en_b;

  // ---------------------------------------------------------------
  // Mode decoding
  // ---------------------------------------------------------------
  function automatic logic is_wide(input mode_t m);
    return (m == MODE_SINGLE) || (m == MODE_TWIN16) ||
           (m == MODE_NRZ) || (m == MODE_RZ);
  endfunction

  function automatic logic is_idle(input mode_t m);
    return (m == MODE_OFF) || (m == MODE_RSVD);
  endfunction

  // ---------------------------------------------------------------
  // Modulator clock
  // ---------------------------------------------------------------
  pwm_clock_gen #(
    .OSC_DIV_LAST(OSC_DIV_LAST)
  ) clock_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(ctl_wr),
    .src_i(st.ctl.clock_source),
    .pre_i(st.ctl.prescale),
    .ext_i(external_count_input_i),
    .tick_o(tick),
    .half_o(half)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    idx = wb_i.adr[ADR_W-1:2];
    d = wb_i.dat[7:0];
    wr = wb_i.cyc && wb_i.stb && st.ack && wb_i.we && wb_i.sel[0];
    ctl_wr = wr && (idx == IDX_CTL);
    wide = is_wide(st.ctl.mode); // [RL6]
    case (st.ctl.mode)
      MODE_SINGLE: wrap = (st.cnt == st.act_b); // [RL10] [RL23]
      MODE_TWIN8, MODE_DUAL8: wrap = (st.cnt[7:0] == st.act_b[7:0]); // [RL11]
      default: wrap = (st.cnt == CNT_TOP); // [RL14]
    endcase
    wrap2 = (st.cnt2 == st.act_b[15:8]);
    la = wrap ? st.stg_a : st.act_a; // [RL7]
    lb = wrap ? st.stg_b : st.act_b;
    nc = wrap ? '0 : st.cnt + 16'h0001;
    nc2 = wrap2 ? '0 : st.cnt2 + 8'h01;
    sa = {1'b0, st.acc_a} + {1'b0, la};
    sb = {1'b0, st.acc_b} + {1'b0, lb};

    // Bus handshake: ack one cycle after the request, then low
    next_st.ack = wb_i.cyc && wb_i.stb && !st.ack;
    if (wb_i.cyc && wb_i.stb && !st.ack)
    begin
      if (idx == IDX_CTL)
        next_st.dat = {24'h000000, st.ctl};
      else if (idx == IDX_A_LO)
        next_st.dat = {24'h000000, st.stg_a[7:0]};
      else if (idx == IDX_A_HI)
        next_st.dat = {24'h000000, st.stg_a[15:8]};
      else if (idx == IDX_B_LO)
        next_st.dat = {24'h000000, st.stg_b[7:0]};
      else if (idx == IDX_B_HI)
        next_st.dat = {24'h000000, st.stg_b[15:8]};
      else if (idx == IDX_ROUTE)
        next_st.dat = {31'h00000000, st.route};
      else if (idx == IDX_COUNT)
        next_st.dat = {14'h0000, st.lvl_b, st.lvl_a, st.cnt};
      else
        next_st.dat = '0;
    end

    // Modulator step on each modulator clock [RL1] [RL18]
    if (tick)
    begin
      next_st.cnt = nc;
      next_st.act_a = la;
      next_st.act_b = lb;
      case (st.ctl.mode)
        MODE_SINGLE:
        begin
          if (wrap)
            next_st.lvl_b = (la != '0); // [RL23]
          else if (nc == la)
            next_st.lvl_b = 1'b0; // [RL10]
        end
        MODE_TWIN8:
        begin
          if (wrap)
            next_st.lvl_a = (la[7:0] != '0); // [RL23]
          else if (nc[7:0] == la[7:0])
            next_st.lvl_a = 1'b0; // [RL12]
          if (nc[7:0] == lb[15:8])
            next_st.lvl_b = 1'b1; // [RL13]
          else if (nc[7:0] == la[15:8])
            next_st.lvl_b = 1'b0; // [RL13]
        end
        MODE_TWIN16:
        begin
          next_st.lvl_a = (nc < la); // [RL15] [RL17]
          next_st.lvl_b = (nc < lb); // [RL16] [RL17]
        end
        MODE_NRZ, MODE_RZ:
        begin
          // Carry of a first-order accumulator spreads highs evenly
          next_st.acc_a = sa[15:0]; // [RL19] [RL20]
          next_st.acc_b = sb[15:0];
          next_st.lvl_a = sa[16]; // [RL18]
          next_st.lvl_b = sb[16];
        end
        MODE_DUAL8:
        begin
          next_st.cnt2 = nc2; // [RL21]
          if (wrap)
            next_st.lvl_a = (la[7:0] != '0);
          else if (nc[7:0] == la[7:0])
            next_st.lvl_a = 1'b0; // [RL21]
          if (wrap2)
            next_st.lvl_b = (la[15:8] != '0);
          else if (nc2 == la[15:8])
            next_st.lvl_b = 1'b0; // [RL21]
        end
        default:
        begin
          next_st.lvl_a = 1'b0;
          next_st.lvl_b = 1'b0;
        end
      endcase
    end
    if (half && (st.ctl.mode == MODE_RZ))
    begin
      next_st.lvl_a = 1'b0; // [RL22]
      next_st.lvl_b = 1'b0;
    end
    if (is_idle(st.ctl.mode))
    begin
      next_st.act_a = st.stg_a;
      next_st.act_b = st.stg_b;
    end

    // Register writes
    if (ctl_wr)
    begin
      next_st.ctl = ctl_t'(d); // [RL1] [RL2] [RL3]
      next_st.cnt = '0; // [RL5]
      next_st.cnt2 = '0;
      next_st.acc_a = '0;
      next_st.acc_b = '0;
      next_st.lvl_a = 1'b0;
      next_st.lvl_b = 1'b0;
    end
    else if (wr && (idx == IDX_A_LO))
    begin
      if (wide)
        next_st.hold_a = d; // [RL6]
      else
        next_st.stg_a[7:0] = d;
    end
    else if (wr && (idx == IDX_A_HI))
    begin
      next_st.stg_a[15:8] = d;
      if (wide)
        next_st.stg_a[7:0] = st.hold_a; // [RL7]
    end
    else if (wr && (idx == IDX_B_LO))
    begin
      if (wide)
        next_st.hold_b = d; // [RL6]
      else
        next_st.stg_b[7:0] = d;
    end
    else if (wr && (idx == IDX_B_HI))
    begin
      next_st.stg_b[15:8] = d;
      if (wide)
        next_st.stg_b[7:0] = st.hold_b; // [RL7]
    end
    else if (wr && (idx == IDX_ROUTE))
    begin
      next_st.route = d[0];
    end

    // Pin drive and routing
    en_a = !is_idle(next_st.ctl.mode) && // [RL9] [RL24]
           (next_st.ctl.mode != MODE_SINGLE) && // [RL10]
           !next_st.ctl.first_output_off; // [RL4]
    en_b = !is_idle(next_st.ctl.mode);
    if (next_st.route) // [RL8]
    begin
      next_st.oe = {en_b, en_a, 2'b00};
      next_st.pin = {next_st.lvl_b & en_b, next_st.lvl_a & en_a, 2'b00};
    end
    else
    begin
      next_st.oe = {2'b00, en_b, en_a};
      next_st.pin = {2'b00, next_st.lvl_b & en_b, next_st.lvl_a & en_a};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '0;
      st.ctl <= ctl_t'(CTL_RESET);
    end
    else
    begin
      st <= next_st;
    end
  end

  assign ack_o = st.ack;
  assign dat_o = st.dat;
  assign first_output_pin_o = st.pin[0];
  assign first_output_pin_oe_o = st.oe[0];
  assign second_output_pin_o = st.pin[1];
  assign second_output_pin_oe_o = st.oe[1];
  assign alternate_first_pin_o = st.pin[2];
  assign alternate_first_pin_oe_o = st.oe[2];
  assign alternate_second_pin_o = st.pin[3];
  assign alternate_second_pin_oe_o = st.oe[3];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence low_a_write_s;
    wr && wide && (idx == IDX_A_LO);
  endsequence

  sequence high_a_write_s;
    wr && wide && (idx == IDX_A_HI);
  endsequence

  counter_clear_a: assert property ( // [RL5]
    ctl_wr |=> (st.cnt == '0) && (st.cnt2 == '0) && !st.lvl_a)
    else $error("counter not cleared by control write");

  hold_low_a: assert property ( // [RL6]
    low_a_write_s |=> (st.stg_a == $past(st.stg_a)) &&
                      (st.hold_a == $past(d)))
    else $error("low byte not held");

  high_xfer_a: assert property ( // [RL7]
    high_a_write_s |=> st.stg_a == {$past(d), $past(st.hold_a)})
    else $error("pair not transferred");

  act_hold_a: assert property ( // [RL7]
    tick && !wrap && !is_idle(st.ctl.mode) && !ctl_wr |=>
      $stable(st.act_a) && $stable(st.act_b))
    else $error("value applied before cycle end");

  idle_release_a: assert property ( // [RL9]
    (st.ctl.mode == MODE_OFF) [*2] |-> (st.oe == '0) && (st.pin == '0))
    else $error("pins driven while disabled");

  reserved_off_a: assert property ( // [RL24]
    (st.ctl.mode == MODE_RSVD) [*2] |-> (st.oe == '0))
    else $error("pins driven in reserved mode");

  first_off_a: assert property ( // [RL4]
    st.ctl.first_output_off [*2] |-> !st.oe[0] && !st.oe[2])
    else $error("first output driven while turned off");

  single_only_a: assert property ( // [RL10]
    (st.ctl.mode == MODE_SINGLE) [*2] |-> !st.oe[0] && !st.oe[2])
    else $error("first output driven in single mode");

  route_sel_a: assert property ( // [RL8]
    (st.route && (st.ctl.mode == MODE_TWIN16)) [*2] |->
      !st.oe[0] && !st.oe[1] && st.oe[3])
    else $error("outputs on wrong pin pair");

  wrap_high_a: assert property ( // [RL17]
    tick && wrap && (st.ctl.mode == MODE_TWIN16) && !ctl_wr &&
    (la != '0) && (lb != '0) |=> st.lvl_a && st.lvl_b)
    else $error("outputs not high together at wrap");

  rz_return_a: assert property ( // [RL22]
    half && (st.ctl.mode == MODE_RZ) && !ctl_wr |=>
      !st.lvl_a && !st.lvl_b)
    else $error("return-to-zero half not low");

endmodule

// file: tb/pin_load_model.sv
`timescale 1ns/10ps
// --------
// Load on one output pin, pulled low while released
// --------
module pin_load_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic clr_i,
  // Pin
  input wire logic pin_i,
  input wire logic oe_i,
  // Observations
  output logic [15:0] high_o,
  output logic [15:0] run_o
);
  logic level;
  logic [15:0] run;

  // A released pin reads the pull-down level
  assign level = oe_i ? pin_i : 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (clr_i)
    begin
      high_o <= 16'h0000;
      run <= 16'h0000;
      run_o <= 16'h0000;
    end
    else if (level)
    begin
      high_o <= high_o + 16'h0001;
      run <= run + 16'h0001;
      if (run + 16'h0001 > run_o)
        run_o <= run + 16'h0001;
    end
    else
      run <= 16'h0000;
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  import pwm_pkg::*;
  logic clk_i;
  logic rst_i;
  wb_req_t wb;
  logic ack;
  logic [31:0] dat;
  logic ext;
  logic [1:0] ec;
  logic clr;
  logic [3:0] p;
  logic [3:0] oe;
  logic [15:0] hi [4];
  logic [15:0] rn [4];
  logic [31:0] q;
  int n_errors;
  int checks;

  // --------
  // Design and pin loads
  // --------
  dual_pwm_sigma_delta_unit #(.OSC_DIV_LAST(8'h01)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .ack_o(ack), .dat_o(dat),
    .external_count_input_i(ext),
    .first_output_pin_o(p[0]), .first_output_pin_oe_o(oe[0]),
    .second_output_pin_o(p[1]), .second_output_pin_oe_o(oe[1]),
    .alternate_first_pin_o(p[2]), .alternate_first_pin_oe_o(oe[2]),
    .alternate_second_pin_o(p[3]), .alternate_second_pin_oe_o(oe[3]));

  for (genvar g = 0; g < 4; g++)
  begin : g_load
    pin_load_model u_load (.clk_i(clk_i), .clr_i(clr), .pin_i(p[g]),
      .oe_i(oe[g]), .high_o(hi[g]), .run_o(rn[g]));
  end

  always #2.5 clk_i = ~clk_i;

  // External source: one rising edge every six clocks
  always @(posedge clk_i)
  begin
    ec <= (ec == 2'd2) ? 2'd0 : ec + 2'd1;
    if (ec == 2'd2)
      ext <= ~ext;
  end

  // --------
  // Bus and compare tasks
  // --------
  task wb_cycle(input logic w, input logic [7:0] i, input logic [7:0] d,
                output logic [31:0] r);
    @(posedge clk_i);
    wb.cyc <= 1'b1;
    wb.stb <= 1'b1;
    wb.we <= w;
    wb.adr <= {i, 2'b00};
    wb.sel <= 4'hF;
    wb.dat <= {24'h000000, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
    begin
      @(posedge clk_i);
    end
    r = dat;
    wb.cyc <= 1'b0;
    wb.stb <= 1'b0;
    wb.we <= 1'b0;
  endtask

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task wr(input logic [7:0] i, input logic [7:0] d);
    wb_cycle(1'b1, i, d, q);
  endtask

  task rdc(input logic [7:0] i, input logic [31:0] e);
    wb_cycle(1'b0, i, 8'h00, q);
    chk("read data", e, q);
  endtask

  task cnt2(input int a, input int b, input int k);
    chk("high count a", a, {16'h0000, hi[k]});
    chk("high count b", b, {16'h0000, hi[k+1]});
  endtask

  task setd(input logic [15:0] a, input logic [15:0] b);
    wr(IDX_CTL, 8'h00);
    wr(IDX_A_LO, a[7:0]);
    wr(IDX_A_HI, a[15:8]);
    wr(IDX_B_LO, b[7:0]);
    wr(IDX_B_HI, b[15:8]);
  endtask

  task win(input int w);
    repeat (w) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Loads are cleared across the control write and s more clocks, then count w clocks
  task run(input logic [7:0] c, input int s, input int w);
    wr(IDX_CTL, 8'h00);
    clr <= 1'b1;
    wr(IDX_CTL, c);
    repeat (s) @(posedge clk_i);
    clr <= 1'b0;
    win(w);
  endtask

  // --------
  // Scenarios
  // --------
  task t_regs;
    rdc(IDX_CTL, {24'h0, CTL_RESET});
    chk("enables", 32'h0, {28'h0, oe});
    wr(8'hC0, 8'h5A);
    rdc(8'hC0, 32'h0);
    wr(IDX_CTL, 8'hB3);
    rdc(IDX_CTL, 32'hB3);
  endtask

  task t_clocks;
    logic [7:0] cc [7];
    int ea [7];
    cc = '{8'h33, 8'h37, 8'h3B, 8'h3F, 8'h32, 8'h31, 8'h30};
    // Levels start low after the clear, so highs span ticks 1..value-1
    ea = '{2, 8, 32, 128, 12, 4, 60};
    setd(16'h0003, 16'h0005);
    for (int k = 0; k < 7; k++)
    begin
      run(cc[k], 0, 450);
      cnt2(ea[k], ea[k] * 2, 0);
    end
    chk("enables", 32'h3, {28'h0, oe});
  endtask

  task t_off;
    run(8'hB3, 0, 100);
    cnt2(0, 4, 0);
    chk("enables", 32'h2, {28'h0, oe});
    wr(IDX_ROUTE, 8'h01);
    run(8'h33, 0, 100);
    cnt2(2, 4, 2);
    chk("enables", 32'hC, {28'h0, oe});
    wr(IDX_ROUTE, 8'h00);
    run(8'h03, 0, 100);
    chk("enables", 32'h0, {28'h0, oe});
    run(8'h73, 0, 100);
    chk("enables", 32'h0, {28'h0, oe});
  endtask

  task t_single;
    setd(16'h0005, 16'h0013);
    run(8'h13, 40, 200);
    chk("high count b", 50, {16'h0, hi[1]});
    chk("enables", 32'h2, {28'h0, oe});
    wr(IDX_A_LO, 8'h09);
    rdc(IDX_A_LO, 32'h05);
    wr(IDX_A_HI, 8'h00);
    rdc(IDX_A_LO, 32'h09);
    @(posedge clk_i);
    clr <= 1'b1;
    repeat (40) @(posedge clk_i);
    clr <= 1'b0;
    win(200);
    chk("high count b", 90, {16'h0, hi[1]});
  endtask

  task t_bytes;
    setd(16'h0203, 16'h0409);
    run(8'h23, 30, 100);
    cnt2(30, 80, 0);
    run(8'h53, 30, 100);
    cnt2(30, 40, 0);
  endtask

  task t_density;
    setd(16'h4000, 16'h8000);
    run(8'h43, 20, 400);
    cnt2(100, 200, 0);
    chk("longest high a", 1, {16'h0, rn[0]});
    run(8'h67, 40, 1600);
    cnt2(200, 400, 0);
    chk("longest high a", 2, {16'h0, rn[0]});
  endtask

  // Full 16-bit period: both outputs rise together at the wrap
  task t_wrap;
    setd(16'h0003, 16'h0005);
    run(8'h33, 65500, 60);
    cnt2(3, 5, 0);
    chk("longest high a", 3, {16'h0, rn[0]});
  endtask

  // --------
  // Sequence and verdict
  // --------
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb = '0;
    ext = 1'b0;
    ec = 2'd0;
    clr = 1'b0;
    n_errors = 0;
    checks = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_clocks;
    t_off;
    t_single;
    t_bytes;
    t_density;
    t_wrap;
    summarize;
  end

  initial
  begin
    repeat (90000) @(posedge clk_i);
    n_errors++;
    summarize;
  end
endmodule
